// File: shared/tone_regs_pkg.sv
// Register layout, field positions and timing constants of the tone transceiver control block
package tone_regs_pkg;
    // ----------------------------------------
    // Control register A fields
    // ----------------------------------------
    localparam int CTLA_TONE_OUT_BIT = 0;
    localparam int CTLA_CALL_PROGRESS_BIT = 1;
    localparam int CTLA_IRQ_ENABLE_BIT = 2;
    localparam int CTLA_SECOND_SELECT_BIT = 3;
    // ----------------------------------------
    // Control register B fields
    // ----------------------------------------
    localparam int CTLB_BURST_N_BIT = 0;
    localparam int CTLB_TEST_BIT = 1;
    localparam int CTLB_SINGLE_BIT = 2;
    localparam int CTLB_COLUMN_BIT = 3;
    // ----------------------------------------
    // Status fields
    // ----------------------------------------
    localparam int ST_IRQ_BIT = 0;
    localparam int ST_TX_EMPTY_BIT = 1;
    localparam int ST_RX_FULL_BIT = 2;
    localparam int ST_ABSENT_BIT = 3;
    // ----------------------------------------
    // Register select line values
    // ----------------------------------------
    localparam logic SEL_DATA = 1'b0;
    localparam logic SEL_CONTROL = 1'b1;
    // ----------------------------------------
    // Reset values (not given; burst off, rest clear)
    // ----------------------------------------
    localparam logic [3:0] CTLA_RESET = 4'h0;
    localparam logic [3:0] CTLB_RESET = 4'h1;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [3:0] RX_DATA_RESET = 4'h0;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int BURST_MS = 51;
    localparam int BURST_CYCLES = BURST_MS * (CLK_HZ / 1000);
endpackage : tone_regs_pkg

// File: rtl/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb
    begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else if (ce_i)
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule : pin_sync

// File: rtl/tone_control_status.sv
// Control and status register logic of the tone-signalling transceiver
//
// Contract
// - Control A b0 enables all tone output
// - Control A b1 selects call-progress or dual-tone
// - Call progress plus irq: square wave out
// - No digit detection in call-progress mode
// - Control A b2 enables interrupt function
// - Interrupt low on digit or tx ready
// - Control A b3 steers next write to B
// - After B write, return to A
// - Control B b0 low enables burst mode
// - Burst write gives tone then equal pause
// - Pause end sets tx empty, interrupts
// - Call progress doubles burst and pause
// - Non-burst tone follows tone enable bit
// - Test mode without call progress: interrupt pin follows absent flag
// - Control B b2 selects single or dual tone
// - Control B b3 selects column or row tone
// - Status b0 set by b1/b2, read clears
// - Tx empty set at pause end, read clears
// - Rx full set on valid digit, read clears
// - Absent flag follows tone detector, not reads
// - Receive data holds latest valid digit
// - Bus style sampled at chip select fall
module tone_control_status #(
    parameter int BURST_CYCLES = tone_regs_pkg::BURST_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    // Adaptive parallel bus pins
    input wire logic chip_select_n_i,
    input wire logic strobe_or_read_i,
    input wire logic rw_or_write_i,
    input wire logic register_select_line_i,
    input wire logic [3:0] data_i,
    output logic [3:0] data_o,
    output logic data_oe_o,
    // Receiver events, same clock
    input wire logic digit_valid_i,
    input wire logic [3:0] digit_code_i,
    input wire logic tone_absent_set_i,
    input wire logic tone_present_set_i,
    input wire logic progress_wave_i,
    // Generator controls
    output logic tone_active_o,
    output logic [3:0] tx_code_o,
    output logic single_tone_o,
    output logic column_tone_o,
    output logic call_progress_select_o,
    output logic digit_detect_enable_o,
    // Open-drain interrupt / call-progress pin
    output logic interrupt_or_progress_out_o,
    output logic interrupt_or_progress_oe_o
);
    // ----------------------------------------
    // Pin synchronisation
    // ----------------------------------------
    logic [7:0] pins_s;
    logic cs_n_s;
    logic ds_s;
    logic rw_s;
    logic rs_s;
    logic [3:0] din_s;

    pin_sync #(.WIDTH(8)) u_sync (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .async_i({chip_select_n_i, strobe_or_read_i, rw_or_write_i,
                  register_select_line_i, data_i}),
        .sync_o(pins_s)
    );
    assign {cs_n_s, ds_s, rw_s, rs_s, din_s} = pins_s;

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    typedef enum logic [1:0] {ACC_NONE, ACC_READ, ACC_WRITE} access_t;

    logic cs_prev_q, cs_prev_d;
    logic style_read_q, style_read_d;
    logic cycle_q, cycle_d;
    access_t acc_q, acc_d;
    logic acc_rs_q, acc_rs_d;
    logic [3:0] acc_data_q, acc_data_d;
    logic wr_done;
    logic rd_done;
    logic is_read;

    // Read while the bus style's direction lines say read
    function automatic logic bus_is_read(input logic read_style, input logic rw, input logic ds);
        bus_is_read = read_style ? !ds : rw;
    endfunction : bus_is_read

    assign is_read = bus_is_read(style_read_q, rw_s, ds_s);

    always_comb
    begin
        cs_prev_d = cs_n_s;
        style_read_d = style_read_q;
        cycle_d = cycle_q;
        acc_d = acc_q;
        acc_rs_d = acc_rs_q;
        acc_data_d = acc_data_q;
        wr_done = 1'b0;
        rd_done = 1'b0;
        if (cs_prev_q && !cs_n_s)
        begin
            // Strobe high at select fall means read-strobe style
            style_read_d = ds_s;
            cycle_d = 1'b1;
            acc_d = ACC_NONE;
        end
        else if (cycle_q && !cs_n_s)
        begin
            // Latch the access while selected; data may be multiplexed earlier
            if (style_read_q ? (!ds_s || !rw_s) : ds_s)
            begin
                acc_d = is_read ? ACC_READ : ACC_WRITE;
                acc_rs_d = rs_s;
                if (!is_read)
                begin
                    acc_data_d = din_s;
                end
            end
        end
        else if (cycle_q && cs_n_s)
        begin
            // Commit at deselect so a read sees flags before they clear
            cycle_d = 1'b0;
            wr_done = (acc_q == ACC_WRITE);
            rd_done = (acc_q == ACC_READ);
            acc_d = ACC_NONE;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cs_prev_q <= 1'b0; // Matches synchroniser reset, no false select fall
            style_read_q <= 1'b0;
            cycle_q <= 1'b0;
            acc_q <= ACC_NONE;
            acc_rs_q <= 1'b0;
            acc_data_q <= 4'h0;
        end
        else if (ce_i)
        begin
            cs_prev_q <= cs_prev_d;
            style_read_q <= style_read_d;
            cycle_q <= cycle_d;
            acc_q <= acc_d;
            acc_rs_q <= acc_rs_d;
            acc_data_q <= acc_data_d;
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [3:0] ctla_q, ctla_d;
    logic [3:0] ctlb_q, ctlb_d;
    logic second_q, second_d;
    logic [3:0] tx_q, tx_d;
    logic [3:0] rx_q, rx_d;
    logic [3:0] flags_q, flags_d;
    logic tx_write;
    logic burst_mode;
    logic cp_mode;
    logic irq_en;
    logic pause_end;

    assign cp_mode = ctla_q[tone_regs_pkg::CTLA_CALL_PROGRESS_BIT];
    assign irq_en = ctla_q[tone_regs_pkg::CTLA_IRQ_ENABLE_BIT];
    assign burst_mode = !ctlb_q[tone_regs_pkg::CTLB_BURST_N_BIT];
    assign tx_write = wr_done && (acc_rs_q == tone_regs_pkg::SEL_DATA);

    always_comb
    begin
        ctla_d = ctla_q;
        ctlb_d = ctlb_q;
        second_d = second_q;
        tx_d = tx_q;
        rx_d = rx_q;
        flags_d = flags_q;
        if (wr_done && acc_rs_q == tone_regs_pkg::SEL_CONTROL)
        begin
            if (second_q)
            begin
                ctlb_d = acc_data_q;
                second_d = 1'b0;
            end
            else
            begin
                ctla_d = acc_data_q;
                second_d = acc_data_q[tone_regs_pkg::CTLA_SECOND_SELECT_BIT];
            end
        end
        if (tx_write)
        begin
            tx_d = acc_data_q;
        end
        // Read clears first so that a same-cycle event wins
        if (rd_done && acc_rs_q == tone_regs_pkg::SEL_CONTROL)
        begin
            flags_d[tone_regs_pkg::ST_TX_EMPTY_BIT] = 1'b0;
            flags_d[tone_regs_pkg::ST_RX_FULL_BIT] = 1'b0;
        end
        if (pause_end)
        begin
            flags_d[tone_regs_pkg::ST_TX_EMPTY_BIT] = 1'b1;
        end
        if (!burst_mode)
        begin
            flags_d[tone_regs_pkg::ST_TX_EMPTY_BIT] = 1'b0;
        end
        if (digit_valid_i && !cp_mode)
        begin
            rx_d = digit_code_i;
            flags_d[tone_regs_pkg::ST_RX_FULL_BIT] = 1'b1;
        end
        if (tone_absent_set_i)
        begin
            flags_d[tone_regs_pkg::ST_ABSENT_BIT] = 1'b1;
        end
        else if (tone_present_set_i)
        begin
            flags_d[tone_regs_pkg::ST_ABSENT_BIT] = 1'b0;
        end
        flags_d[tone_regs_pkg::ST_IRQ_BIT] = flags_d[tone_regs_pkg::ST_TX_EMPTY_BIT]
            | flags_d[tone_regs_pkg::ST_RX_FULL_BIT];
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ctla_q <= tone_regs_pkg::CTLA_RESET;
            ctlb_q <= tone_regs_pkg::CTLB_RESET;
            second_q <= 1'b0;
            tx_q <= 4'h0;
            rx_q <= tone_regs_pkg::RX_DATA_RESET;
            flags_q <= tone_regs_pkg::FLAGS_RESET;
        end
        else if (ce_i)
        begin
            ctla_q <= ctla_d;
            ctlb_q <= ctlb_d;
            second_q <= second_d;
            tx_q <= tx_d;
            rx_q <= rx_d;
            flags_q <= flags_d;
        end
    end

    // ----------------------------------------
    // Burst timer
    // ----------------------------------------
    typedef enum logic [1:0] {B_IDLE, B_TONE, B_PAUSE} burst_t;

    burst_t bst_q, bst_d;
    logic [31:0] cnt_q, cnt_d;
    logic [31:0] phase_len;

    // Call progress doubles both phases
    assign phase_len = cp_mode ? 32'(2 * BURST_CYCLES) : 32'(BURST_CYCLES);

    always_comb
    begin
        bst_d = bst_q;
        cnt_d = cnt_q;
        pause_end = 1'b0;
        unique case (bst_q)
            B_IDLE:
            begin
                if (tx_write && burst_mode)
                begin
                    bst_d = B_TONE;
                    cnt_d = phase_len - 32'd1;
                end
            end
            B_TONE:
            begin
                if (cnt_q == 32'd0)
                begin
                    bst_d = B_PAUSE;
                    cnt_d = phase_len - 32'd1;
                end
                else
                begin
                    cnt_d = cnt_q - 32'd1;
                end
            end
            B_PAUSE:
            begin
                if (cnt_q == 32'd0)
                begin
                    bst_d = B_IDLE;
                    pause_end = 1'b1;
                end
                else
                begin
                    cnt_d = cnt_q - 32'd1;
                end
            end
        endcase
        if (!burst_mode)
        begin
            bst_d = B_IDLE;
            pause_end = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            bst_q <= B_IDLE;
            cnt_q <= 32'd0;
        end
        else if (ce_i)
        begin
            bst_q <= bst_d;
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    logic pin_low_q, pin_low_d;
    logic [3:0] dout_q, dout_d;
    logic tone_q, tone_d;

    always_comb
    begin
        // Tone enable gates both burst and continuous tones
        tone_d = ctla_q[tone_regs_pkg::CTLA_TONE_OUT_BIT]
            && (burst_mode ? (bst_q == B_TONE) : 1'b1);
        dout_d = (rs_s == tone_regs_pkg::SEL_CONTROL) ? flags_q : rx_q;
        if (cp_mode)
        begin
            pin_low_d = irq_en && !progress_wave_i;
        end
        else if (ctlb_q[tone_regs_pkg::CTLB_TEST_BIT])
        begin
            pin_low_d = !flags_q[tone_regs_pkg::ST_ABSENT_BIT];
        end
        else
        begin
            pin_low_d = irq_en && flags_q[tone_regs_pkg::ST_IRQ_BIT];
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pin_low_q <= 1'b0;
            dout_q <= 4'h0;
            tone_q <= 1'b0;
        end
        else if (ce_i)
        begin
            pin_low_q <= pin_low_d;
            dout_q <= dout_d;
            tone_q <= tone_d;
        end
    end

    assign data_o = dout_q;
    assign data_oe_o = cycle_q && !cs_n_s && is_read;
    assign tone_active_o = tone_q;
    assign tx_code_o = tx_q;
    assign single_tone_o = ctlb_q[tone_regs_pkg::CTLB_SINGLE_BIT];
    assign column_tone_o = ctlb_q[tone_regs_pkg::CTLB_COLUMN_BIT];
    assign call_progress_select_o = cp_mode;
    assign digit_detect_enable_o = !cp_mode;
    assign interrupt_or_progress_out_o = 1'b0;
    assign interrupt_or_progress_oe_o = pin_low_q;
endmodule : tone_control_status

// File: tb/tone_host_model.sv
// Host processor model driving the adaptive parallel bus
module tone_host_model (
    input wire logic clk_sys_i,
    input wire logic [3:0] rdata_i,
    output logic cs_n_o,
    output logic strb_o,
    output logic rw_o,
    output logic rs_o,
    output logic [3:0] wdata_o,
    output logic rd_valid_o,
    output logic [3:0] rd_data_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        cs_n_o = 1'b1;
        strb_o = 1'b0;
        rw_o = 1'b1;
        rs_o = 1'b0;
        wdata_o = 4'h0;
        rd_valid_o = 1'b0;
        rd_data_o = 4'h0;
    end
    // Strobe or write line moved late so the style is sampled with the strobe idle
    task automatic access(input logic rd_style, input logic rs, input logic rd,
        input logic [3:0] d);
    begin
        @(negedge clk_sys_i);
        cs_n_o = 1'b0;
        strb_o = rd_style;
        rw_o = rd_style | rd;
        rs_o = rs;
        wdata_o = d;
        repeat (3) @(negedge clk_sys_i);
        if (!rd_style)
            strb_o = 1'b1;
        else if (rd)
            strb_o = 1'b0;
        else
            rw_o = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        rd_data_o = rdata_i;
        rd_valid_o = rd;
        cs_n_o = 1'b1;
        strb_o = rd_style;
        rw_o = 1'b1;
        wdata_o = ~d; // Released bus shows no stale value
        @(negedge clk_sys_i);
        rd_valid_o = 1'b0;
        repeat (4) @(negedge clk_sys_i);
    end
    endtask : access
endmodule : tone_host_model

// File: tb/tone_control_status_asserts.sv
// Port checker for the tone control and status block
module tone_control_status_asserts #(
    parameter int BURST_CYCLES = 8
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic ce_i,
    input wire logic chip_select_n_i,
    input wire logic data_oe_o,
    input wire logic progress_wave_i,
    input wire logic tone_active_o,
    input wire logic [3:0] tx_code_o,
    input wire logic single_tone_o,
    input wire logic column_tone_o,
    input wire logic call_progress_select_o,
    input wire logic digit_detect_enable_o,
    input wire logic interrupt_or_progress_out_o,
    input wire logic interrupt_or_progress_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);
    logic [31:0] run_q;
    logic [31:0] run_d;
    always_comb run_d = tone_active_o ? run_q + 32'h1 : 32'h0;
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
        if (!arst_n_i)
            run_q <= 32'h0;
        else
            run_q <= run_d;
    // -----------
    // Properties
    // -----------
    property p_mode_excl; call_progress_select_o != digit_detect_enable_o; endproperty
    a_mode_excl: assert property (p_mode_excl)
        else $error("detect enable not inverse of mode");
    property p_drain; interrupt_or_progress_out_o == 1'b0; endproperty
    a_drain: assert property (p_drain)
        else $error("open drain pin driven high");
    property p_wave; call_progress_select_o && progress_wave_i |=>
        !interrupt_or_progress_oe_o; endproperty
    a_wave: assert property (p_wave)
        else $error("pin not following progress wave");
    property p_mode_cs; $changed(call_progress_select_o) |-> $past(chip_select_n_i, 2);
    endproperty
    a_mode_cs: assert property (p_mode_cs)
        else $error("mode changed without bus cycle");
    property p_shape_cs; $changed({single_tone_o, column_tone_o}) |->
        $past(chip_select_n_i, 2); endproperty
    a_shape_cs: assert property (p_shape_cs)
        else $error("tone shape changed without bus cycle");
    property p_code_cs; $changed(tx_code_o) |-> $past(chip_select_n_i, 2); endproperty
    a_code_cs: assert property (p_code_cs)
        else $error("transmit code changed without bus cycle");
    property p_tone_cs; $rose(tone_active_o) |-> $past(chip_select_n_i, 2); endproperty
    a_tone_cs: assert property (p_tone_cs)
        else $error("tone started without bus cycle");
    property p_freeze; !ce_i |=> $stable(tone_active_o) && $stable(interrupt_or_progress_oe_o);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("outputs moved while clock enable low");
    property p_oe_sel; data_oe_o && $past(ce_i) && $past(ce_i, 2) |->
        !$past(chip_select_n_i, 2); endproperty
    a_oe_sel: assert property (p_oe_sel)
        else $error("data enable without chip select");
    c_burst: cover property ($fell(tone_active_o) && run_q == BURST_CYCLES);
    c_irq: cover property ($rose(interrupt_or_progress_oe_o));
    c_wave: cover property (call_progress_select_o && progress_wave_i);
endmodule : tone_control_status_asserts

bind tone_control_status tone_control_status_asserts #(.BURST_CYCLES(BURST_CYCLES)) u_chk (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .chip_select_n_i(chip_select_n_i), .data_oe_o(data_oe_o),
    .progress_wave_i(progress_wave_i),
    .tone_active_o(tone_active_o), .tx_code_o(tx_code_o), .single_tone_o(single_tone_o),
    .column_tone_o(column_tone_o), .call_progress_select_o(call_progress_select_o),
    .digit_detect_enable_o(digit_detect_enable_o),
    .interrupt_or_progress_out_o(interrupt_or_progress_out_o),
    .interrupt_or_progress_oe_o(interrupt_or_progress_oe_o));

// File: tb/tb_dtmf_transceiver_control_status.sv
// Self-checking bench of the tone control and status block
module tb_dtmf_transceiver_control_status;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BURST = 8;
    logic clk, arst_n, ce, cs_n, strb, rw, rs, dv, abs_set, pres_set, wave;
    logic tone, single, column, cp, det_en, irq_out, irq_oe, rd_valid, data_oe;
    logic [3:0] wdata, rdata, dcode, tx_code, rd_data;
    logic [3:0] exp_q[$];
    logic [7:0] run, last_run;
    logic [31:0] rnd = 32'h0000000A;
    int n_mismatch, checks_done, n;
    tone_control_status #(.BURST_CYCLES(BURST)) uut (.clk_sys_i(clk), .arst_n_i(arst_n),
        .ce_i(ce), .chip_select_n_i(cs_n), .strobe_or_read_i(strb), .rw_or_write_i(rw),
        .register_select_line_i(rs), .data_i(wdata), .data_o(rdata), .data_oe_o(data_oe),
        .digit_valid_i(dv), .digit_code_i(dcode), .tone_absent_set_i(abs_set),
        .tone_present_set_i(pres_set), .progress_wave_i(wave), .tone_active_o(tone),
        .tx_code_o(tx_code), .single_tone_o(single), .column_tone_o(column),
        .call_progress_select_o(cp), .digit_detect_enable_o(det_en),
        .interrupt_or_progress_out_o(irq_out), .interrupt_or_progress_oe_o(irq_oe));
    tone_host_model host (.clk_sys_i(clk), .rdata_i(rdata), .cs_n_o(cs_n), .strb_o(strb),
        .rw_o(rw), .rs_o(rs), .wdata_o(wdata), .rd_valid_o(rd_valid), .rd_data_o(rd_data));
    always #10 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs
    task automatic check_val(input string name, input logic [7:0] exp, input logic [7:0] seen);
    begin
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    end
    endtask : check_val
    task summarize;
    begin
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask : summarize
    task automatic wr(input logic sel, input logic [3:0] d);
        host.access(1'b0, sel, 1'b0, d);
    endtask : wr
    task automatic rd(input logic sel, input logic [3:0] e);
    begin
        exp_q.push_back(e);
        host.access(1'b0, sel, 1'b1, 4'h0);
    end
    endtask : rd
    task automatic pulse(input int sel);
    begin
        @(negedge clk);
        dv = (sel == 0);
        abs_set = (sel == 1);
        pres_set = (sel == 2);
        @(negedge clk);
        {dv, abs_set, pres_set} = 3'h0;
    end
    endtask : pulse
    task automatic tone_done;
    begin
        for (n = 0; n < 100 && tone !== 1'b0; n++)
            @(negedge clk);
        @(negedge clk);
    end
    endtask : tone_done
    always @(posedge clk)
    begin
        if (tone === 1'b1)
            run <= run + 8'h01;
        else if (run != 8'h00)
        begin
            last_run <= run;
            run <= 8'h00;
        end
        if (rd_valid)
        begin
            check_val("read_data", 8'(exp_q.pop_front()), 8'(rd_data));
            check_val("data_oe", 8'h01, 8'(data_oe));
        end
    end
    // Run needs about 560 cycles; hang cut off well beyond
    initial
    begin
        repeat (6000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
    initial
    begin
        {clk, arst_n, dv, abs_set, pres_set, wave} = 6'h00;
        {ce, dcode, run, last_run} = 21'h100000;
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        repeat (2) @(negedge clk);
        check_val("det_en", 8'h01, 8'(det_en));
        rd(1'b1, 4'h0);
        wr(1'b1, 4'h0);
        wr(1'b1, 4'h8);
        wr(1'b1, 4'h0);
        wr(1'b1, 4'h8);
        wr(1'b1, 4'hC);
        check_val("single", 8'h01, 8'(single));
        check_val("column", 8'h01, 8'(column));
        wr(1'b1, 4'h6);
        check_val("cp", 8'h01, 8'(cp));
        check_val("det_en", 8'h00, 8'(det_en));
        check_val("single", 8'h01, 8'(single));
        wave = 1'b1;
        repeat (2) @(negedge clk);
        check_val("irq_oe", 8'h00, 8'(irq_oe));
        wave = 1'b0;
        repeat (2) @(negedge clk);
        check_val("irq_oe", 8'h01, 8'(irq_oe));
        pulse(0);
        rd(1'b1, 4'h0);
        wr(1'b1, 4'hD);
        wr(1'b1, 4'h0);
        wr(1'b0, 4'h7);
        check_val("tx_code", 8'h07, 8'(tx_code));
        tone_done();
        check_val("burst_len", 8'(BURST), last_run);
        for (n = 0; n < 100 && irq_oe !== 1'b1; n++)
            @(negedge clk);
        check_val("pause", 8'h01, 8'(n >= BURST - 2 && n <= BURST + 2));
        rd(1'b1, 4'h3);
        check_val("irq_oe", 8'h00, 8'(irq_oe));
        rd(1'b1, 4'h0);
        wr(1'b1, 4'hB);
        wr(1'b1, 4'h0);
        wr(1'b0, 4'h5);
        tone_done();
        check_val("burst_len", 8'(2 * BURST), last_run);
        repeat (2 * BURST + 4) @(negedge clk);
        check_val("irq_oe", 8'h00, 8'(irq_oe));
        rd(1'b1, 4'h3);
        wr(1'b1, 4'h5);
        ce = 1'b0;
        repeat (3) @(negedge clk);
        ce = 1'b1;
        repeat (3)
        begin
            rnd = xs(rnd);
            dcode = rnd[3:0];
            pulse(0);
            repeat (3) @(negedge clk);
            check_val("irq_oe", 8'h01, 8'(irq_oe));
            rd(1'b1, 4'h5);
            rd(1'b0, dcode);
        end
        pulse(1);
        rd(1'b1, 4'h8);
        rd(1'b1, 4'h8);
        wr(1'b1, 4'h8);
        wr(1'b1, 4'h3);
        check_val("irq_oe", 8'h00, 8'(irq_oe));
        pulse(2);
        repeat (2) @(negedge clk);
        check_val("irq_oe", 8'h01, 8'(irq_oe));
        wr(1'b0, 4'h9);
        check_val("tone", 8'h00, 8'(tone));
        wr(1'b1, 4'h1);
        repeat (3 * BURST) @(negedge clk);
        check_val("tone", 8'h01, 8'(tone));
        rd(1'b1, 4'h0);
        wr(1'b1, 4'h0);
        check_val("tone", 8'h00, 8'(tone));
        exp_q.push_back(4'h0);
        host.access(1'b1, 1'b1, 1'b1, 4'h0);
        host.access(1'b1, 1'b0, 1'b0, 4'hA);
        check_val("tx_code", 8'h0A, 8'(tx_code));
        summarize();
    end
endmodule : tb_dtmf_transceiver_control_status
